/* rtl/swf_cfg.svh */
/*
 constants for the flash read / watermark block: offsets, reset values,
 encodings. assumes byte addresses on an 8-bit register port.
*/
// Function
// R1 - enable bits: tx bit0, rx bit1, reset zero
// R2 - pending register is read-only
// R3 - tx pending when tx level below mark
// R4 - tx pending clears once level reaches mark
// R5 - rx pending when rx level above mark
// R6 - rx pending clears once level drops to mark
// R7 - control bit0 selects flash mode, resets one
// R8 - mapped access runs whole flash read
// R9 - order: command, address, dummy, data
// R10 - format bit0 enables command phase
// R11 - format bits 3:1 address bytes 0..4
// R12 - format bits 7:4 dummy cycle count
// R13 - format bits 9:8 command lane protocol
// R14 - format bits 11:10 address/dummy protocol
// R15 - format bits 13:12 data protocol
// R16 - format bits 23:16 command byte, resets 3
// R17 - format bits 31:24 first dummy bits
// R18 - protocol 0 single, 1 dual, 2 quad
// R19 - three-bit tx and rx mark registers
// R20 - interrupt when pending and enabled
`ifndef SWF_CFG_SVH
`define SWF_CFG_SVH
`define SWF_OFF_TXMARK 8'h50
`define SWF_OFF_RXMARK 8'h54
`define SWF_OFF_FLASH_CTL 8'h60
`define SWF_OFF_READ_FMT 8'h64
`define SWF_OFF_IRQ_EN 8'h70
`define SWF_OFF_IRQ_PEND 8'h74
`define SWF_RST_TXMARK 3'h1
`define SWF_RST_RXMARK 3'h0
`define SWF_RST_FLASH_CTL 1'h1
`define SWF_RST_READ_FMT 32'h0003_0007
`define SWF_RST_IRQ_EN 2'h0
`define SWF_PROTO_SINGLE 2'h0
`define SWF_PROTO_DUAL 2'h1
`define SWF_PROTO_QUAD 2'h2
`define SWF_ADDR_MAX 3'h4
`define SWF_SCK_HALF 4
`define SWF_BITS_BYTE 6'h08
`define SWF_BITS_WORD 6'h20
`endif

/* rtl/swf_pkg.sv */
/*
 types for the flash read / watermark block.
 assumes swf_cfg.svh supplies the numeric constants.
*/
package swf_pkg;
   // format register layout, msb first
   typedef struct packed {
      logic [7:0] pad_code;
      logic [7:0] cmd_code;
      logic [1:0] rsvd;
      logic [1:0] data_proto;
      logic [1:0] addr_proto;
      logic [1:0] cmd_proto;
      logic [3:0] pad_cnt;
      logic [2:0] addr_len;
      logic cmd_en;
   } swf_fmt_t;

   typedef struct packed {
      logic rx;
      logic tx;
   } swf_wm_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_PAD,
      ST_DATA
   } swf_state_t;
endpackage

/* rtl/swf_top.sv */
/*
 watermark interrupt logic and memory-mapped flash read sequencer.
 assumes fifo levels come from logic on ref_clk; dq inputs are pins.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "swf_cfg.svh"
module swf_top #(
   parameter int LVL_W = 4,
   parameter int SCK_HALF = `SWF_SCK_HALF
) (
   input wire logic ref_clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, next cycle
   input wire logic [LVL_W-1:0] tx_level, // tx fifo occupancy
   input wire logic [LVL_W-1:0] rx_level, // rx fifo occupancy
   output logic irq, // watermark interrupt
   input wire logic mm_req, // mapped read request pulse
   input wire logic [31:0] mm_addr, // flash byte address
   output logic mm_busy, // read in progress
   output logic mm_done, // read finished pulse
   output logic mm_err, // refused, flash mode off
   output logic [31:0] mm_rdata, // read word
   output logic sck, // flash clock
   output logic cs_n, // flash select, low
   output logic [3:0] dq_o, // data lanes out
   output logic [3:0] dq_oe, // data lanes drive enable
   input wire logic [3:0] dq_i // data lanes in
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0] txmark_reg;
   logic [2:0] rxmark_reg;
   logic flash_ctl_reg;
   swf_pkg::swf_fmt_t read_fmt_reg;
   swf_pkg::swf_wm_t irq_en_reg;
   swf_pkg::swf_wm_t pend_reg;
   swf_pkg::swf_wm_t pend_next;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         txmark_reg <= `SWF_RST_TXMARK;
         rxmark_reg <= `SWF_RST_RXMARK;
         flash_ctl_reg <= `SWF_RST_FLASH_CTL; // R7
         read_fmt_reg <= `SWF_RST_READ_FMT; // R10 R11 R12 R16
         irq_en_reg <= `SWF_RST_IRQ_EN; // R1
      end
      else if (reg_wr)
         unique case (reg_addr)
            `SWF_OFF_TXMARK: txmark_reg <= reg_wdata[2:0]; // R19
            `SWF_OFF_RXMARK: rxmark_reg <= reg_wdata[2:0]; // R19
            `SWF_OFF_FLASH_CTL: flash_ctl_reg <= reg_wdata[0];
            `SWF_OFF_READ_FMT: read_fmt_reg <= reg_wdata;
            `SWF_OFF_IRQ_EN: irq_en_reg <= reg_wdata[1:0]; // R1
            default: ; // R2
         endcase
   end

   // pending is never written by software, writes to its offset drop
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= 32'h0;
      else if (reg_rd)
         unique case (reg_addr)
            `SWF_OFF_TXMARK: reg_rdata <= {29'h0, txmark_reg};
            `SWF_OFF_RXMARK: reg_rdata <= {29'h0, rxmark_reg};
            `SWF_OFF_FLASH_CTL: reg_rdata <= {31'h0, flash_ctl_reg};
            `SWF_OFF_READ_FMT: reg_rdata <= {read_fmt_reg[31:16], 2'h0,
                                             read_fmt_reg[13:0]};
            `SWF_OFF_IRQ_EN: reg_rdata <= {30'h0, irq_en_reg};
            `SWF_OFF_IRQ_PEND: reg_rdata <= {30'h0, pend_reg}; // R2
            default: reg_rdata <= 32'h0;
         endcase
      else
         reg_rdata <= 32'h0;
   end

   // ------------------------------------------------------------
   // watermarks
   // ------------------------------------------------------------
   // level-based: the bit follows the fifo, so it clears by itself
   always_comb
   begin
      pend_next.tx = tx_level < LVL_W'(txmark_reg); // R3 R4
      pend_next.rx = rx_level > LVL_W'(rxmark_reg); // R5 R6
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pend_reg <= 2'h0;
      else
         pend_reg <= pend_next;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(pend_reg & irq_en_reg); // R1 R20
   end

   // ------------------------------------------------------------
   // flash sequencer
   // ------------------------------------------------------------
   swf_pkg::swf_state_t state;
   swf_pkg::swf_state_t nxt;
   swf_pkg::swf_fmt_t fmt_lat;
   swf_pkg::swf_fmt_t fmt_c;
   logic [31:0] addr_lat;
   logic [31:0] addr_c;
   logic [31:0] sr;
   logic [31:0] ld_sr;
   logic [31:0] rx_sr;
   logic [5:0] cnt;
   logic [5:0] ld_cnt;
   logic [2:0] alen_c;
   logic [1:0] ld_lsh;
   logic [1:0] cur_proto;
   logic [$clog2(SCK_HALF+1)-1:0] div;
   logic tick;
   logic start;
   logic last;
   logic [3:0] dq_s1;
   logic [3:0] dq_s2;

   function automatic logic [1:0] lane_shift(input logic [1:0] p);
      // unknown encoding falls back to single lane
      unique case (p)
         `SWF_PROTO_DUAL: lane_shift = 2'h1; // R18
         `SWF_PROTO_QUAD: lane_shift = 2'h2; // R18
         default: lane_shift = 2'h0;
      endcase
   endfunction

   // a format change mid-read must not disturb it: use latched copy
   assign fmt_c = (state == swf_pkg::ST_IDLE) ? read_fmt_reg : fmt_lat;
   assign addr_c = (state == swf_pkg::ST_IDLE) ? mm_addr : addr_lat;
   assign alen_c = (fmt_c.addr_len > `SWF_ADDR_MAX) ? `SWF_ADDR_MAX
                   : fmt_c.addr_len; // R11
   assign start = mm_req && (state == swf_pkg::ST_IDLE) && flash_ctl_reg;
   assign tick = (div == ($bits(div))'(SCK_HALF - 1));
   assign last = (cnt == 6'h1);

   // phase after the current one; empty phases are skipped
   always_comb
   begin
      nxt = swf_pkg::ST_DATA;
      unique case (state)
         swf_pkg::ST_IDLE: // R9
            if (fmt_c.cmd_en) // R10
               nxt = swf_pkg::ST_CMD;
            else if (alen_c != 3'h0)
               nxt = swf_pkg::ST_ADDR;
            else if (fmt_c.pad_cnt != 4'h0)
               nxt = swf_pkg::ST_PAD;
         swf_pkg::ST_CMD: // R9
            if (alen_c != 3'h0)
               nxt = swf_pkg::ST_ADDR;
            else if (fmt_c.pad_cnt != 4'h0)
               nxt = swf_pkg::ST_PAD;
         swf_pkg::ST_ADDR: // R9
            if (fmt_c.pad_cnt != 4'h0)
               nxt = swf_pkg::ST_PAD;
         swf_pkg::ST_PAD: nxt = swf_pkg::ST_DATA;
         swf_pkg::ST_DATA: nxt = swf_pkg::ST_IDLE;
      endcase
   end

   always_comb
   begin
      ld_sr = 32'h0;
      ld_cnt = `SWF_BITS_WORD;
      ld_lsh = 2'h0;
      unique case (nxt)
         swf_pkg::ST_CMD:
         begin
            ld_lsh = lane_shift(fmt_c.cmd_proto); // R13
            ld_sr = {fmt_c.cmd_code, 24'h0}; // R16
            ld_cnt = `SWF_BITS_BYTE >> ld_lsh;
         end
         swf_pkg::ST_ADDR:
         begin
            ld_lsh = lane_shift(fmt_c.addr_proto); // R14
            ld_sr = addr_c << (6'(`SWF_ADDR_MAX - alen_c) * 6'h8);
            ld_cnt = 6'({alen_c, 3'h0} >> ld_lsh); // R11
         end
         swf_pkg::ST_PAD:
         begin
            ld_sr = {fmt_c.pad_code, 24'h0}; // R17
            ld_cnt = {2'h0, fmt_c.pad_cnt}; // R12
         end
         swf_pkg::ST_DATA:
         begin
            ld_lsh = lane_shift(fmt_c.data_proto); // R15
            ld_cnt = `SWF_BITS_WORD >> ld_lsh;
         end
         swf_pkg::ST_IDLE: ;
      endcase
   end

   always_comb
   begin
      cur_proto = `SWF_PROTO_SINGLE;
      unique case (state)
         swf_pkg::ST_CMD: cur_proto = fmt_c.cmd_proto; // R13
         swf_pkg::ST_ADDR,
         swf_pkg::ST_PAD: cur_proto = fmt_c.addr_proto; // R14
         swf_pkg::ST_DATA: cur_proto = fmt_c.data_proto; // R15
         swf_pkg::ST_IDLE: cur_proto = `SWF_PROTO_SINGLE;
      endcase
   end

   // input synchroniser for the data pins
   always_ff @(posedge ref_clk)
   begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
   end
   // half-period enable; idle only while no read runs
   always_ff @(posedge ref_clk)
   begin
      if (rst || state == swf_pkg::ST_IDLE || tick)
         div <= '0;
      else
         div <= div + 1'b1;
   end

   // sck low-to-high samples, high-to-low shifts or changes phase
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= swf_pkg::ST_IDLE;
         sck <= 1'b0;
         cs_n <= 1'b1;
         sr <= 32'h0;
         cnt <= 6'h0;
         fmt_lat <= `SWF_RST_READ_FMT;
         addr_lat <= 32'h0;
      end
      else if (start) // R8
      begin
         fmt_lat <= read_fmt_reg;
         addr_lat <= mm_addr;
         cs_n <= 1'b0;
         sck <= 1'b0;
         state <= nxt;
         sr <= ld_sr;
         cnt <= ld_cnt;
      end
      else if (state != swf_pkg::ST_IDLE && tick)
      begin
         sck <= ~sck;
         if (sck && last)
         begin
            state <= nxt; // R9
            sr <= ld_sr;
            cnt <= ld_cnt;
            if (nxt == swf_pkg::ST_IDLE)
               cs_n <= 1'b1;
         end
         else if (sck)
         begin
            sr <= sr << (6'h1 << lane_shift(cur_proto));
            cnt <= cnt - 6'h1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rx_sr <= 32'h0;
      else if (state == swf_pkg::ST_DATA && tick && !sck)
         unique case (lane_shift(cur_proto)) // R18
            2'h1: rx_sr <= {rx_sr[29:0], dq_s2[1:0]};
            2'h2: rx_sr <= {rx_sr[27:0], dq_s2};
            default: rx_sr <= {rx_sr[30:0], dq_s2[1]};
         endcase
   end

   // first flash byte lands in the lowest byte lane
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mm_done <= 1'b0;
         mm_err <= 1'b0;
         mm_rdata <= 32'h0;
      end
      else
      begin
         mm_done <= 1'b0;
         mm_err <= 1'b0;
         if (mm_req && state == swf_pkg::ST_IDLE && !flash_ctl_reg)
         begin
            mm_done <= 1'b1; // R7
            mm_err <= 1'b1;
            mm_rdata <= 32'h0;
         end
         else if (state == swf_pkg::ST_DATA && tick && sck && last)
         begin
            mm_done <= 1'b1;
            mm_rdata <= {rx_sr[7:0], rx_sr[15:8], rx_sr[23:16],
                         rx_sr[31:24]};
         end
      end
   end

   assign mm_busy = (state != swf_pkg::ST_IDLE);

   // unused lanes float; single data keeps dq0 driven low
   always_comb
   begin
      dq_o = 4'h0;
      dq_oe = 4'h0;
      unique case (lane_shift(cur_proto)) // R18
         2'h1:
         begin
            dq_o = {2'h0, sr[31:30]};
            dq_oe = 4'h3;
         end
         2'h2:
         begin
            dq_o = sr[31:28];
            dq_oe = 4'hf;
         end
         default:
         begin
            dq_o = {3'h0, sr[31]};
            dq_oe = 4'h1;
         end
      endcase
      if (state == swf_pkg::ST_IDLE)
         dq_oe = 4'h0;
      else if (state == swf_pkg::ST_DATA)
      begin
         dq_o = 4'h0;
         if (lane_shift(cur_proto) != 2'h0)
            dq_oe = 4'h0; // R15
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_tx_wm_set: assert property ( // R3
      tx_level < LVL_W'(txmark_reg) |=> pend_reg.tx)
      else $error("tx watermark not raised");
   a_tx_wm_clr: assert property ( // R4
      tx_level >= LVL_W'(txmark_reg) |=> !pend_reg.tx)
      else $error("tx watermark not cleared");
   a_rx_wm_set: assert property ( // R5
      rx_level > LVL_W'(rxmark_reg) |=> pend_reg.rx)
      else $error("rx watermark not raised");
   a_rx_wm_clr: assert property ( // R6
      rx_level <= LVL_W'(rxmark_reg) |=> !pend_reg.rx)
      else $error("rx watermark not cleared");
   a_pend_read_back: assert property ( // R2
      reg_rd && reg_addr == `SWF_OFF_IRQ_PEND
      |=> reg_rdata == {30'h0, $past(pend_reg)})
      else $error("pending read mismatch");
   a_irq_gating: assert property ( // R20
      (pend_reg & irq_en_reg) == 2'h0 ##1 (pend_reg & irq_en_reg) == 2'h0
      |=> !irq)
      else $error("interrupt without enabled pending");
   a_flash_off_err: assert property ( // R7
      mm_req && !flash_ctl_reg && !mm_busy |=> mm_done && mm_err)
      else $error("request not refused in off mode");
   a_read_starts: assert property (start |=> !cs_n && mm_busy) // R8
      else $error("read did not start");
   a_cmd_first: assert property ( // R10
      start && read_fmt_reg.cmd_en |=> state == swf_pkg::ST_CMD)
      else $error("command phase not first");
   a_data_float: assert property ( // R15
      state == swf_pkg::ST_DATA
      && fmt_lat.data_proto inside {`SWF_PROTO_DUAL, `SWF_PROTO_QUAD}
      |-> dq_oe == 4'h0)
      else $error("lanes driven during multi-lane data");

   c_cmd_phase: cover property (state == swf_pkg::ST_CMD);
   c_pad_phase: cover property (state == swf_pkg::ST_PAD);
   c_read_done: cover property (mm_done && !mm_err);
   c_irq: cover property (irq);
endmodule

/* tb/swf_flash_model.sv */
/*
 behavioural serial flash for the flash read sequencer.
 assumes the bench hands it the same format word that the block holds.
*/
`timescale 1ns/10ps
module swf_flash_model (
   input wire logic ref_clk, // system clock, idle pattern only
   input wire logic sck, // flash clock
   input wire logic cs_n, // flash select, low
   input wire logic [3:0] dq_o, // lanes from block
   input wire logic [3:0] dq_oe, // lane drive enables
   input wire swf_pkg::swf_fmt_t fmt, // read format in use
   input wire logic [31:0] word, // data to return
   output logic [3:0] dq_i, // lanes to block
   output logic [63:0] cap, // header bits seen
   output int bad // lane enable faults
);
   int rc, k, cw, aw, dw, cmdc, hdr, w;
   function automatic int wid(input logic [1:0] p);
      return p == 2'h1 ? 2 : (p == 2'h2 ? 4 : 1);
   endfunction
   function automatic logic [3:0] chunk(input int n);
      logic [3:0] c;
      int i;
      c = 4'h0;
      for (i = 0; i < dw; i++)
         c[dw-1-i] = word[8*((n*dw+i)/8) + 7 - (n*dw+i)%8];
      return dw == 1 ? {2'h0, c[0], 1'b0} : c;
   endfunction
   always_comb
   begin
      cw = wid(fmt.cmd_proto);
      aw = wid(fmt.addr_proto);
      dw = wid(fmt.data_proto);
      cmdc = fmt.cmd_en ? 8 / cw : 0;
      hdr = cmdc + 8 * (fmt.addr_len > 3'h4 ? 4 : int'(fmt.addr_len)) / aw
            + int'(fmt.pad_cnt);
   end
   initial
   begin
      dq_i = 4'h0;
      cap = 64'h0;
      bad = 0;
      rc = 0;
      k = 0;
   end
   always @(negedge cs_n)
   begin
      rc = 0;
      k = 0;
      cap = 64'h0;
      if (hdr == 0)
      begin
         dq_i = chunk(0);
         k = 1;
      end
   end
   // ---------------------------------------------
   // lanes sampled on rise, answered on fall
   // ---------------------------------------------
   always @(posedge sck)
   begin
      if (rc < hdr)
      begin
         w = rc < cmdc ? cw : aw;
         if (dq_oe !== 4'((1 << w) - 1))
            bad++;
         cap = (cap << w) | 64'(dq_o & 4'((1 << w) - 1));
      end
      else if (dw > 1 && dq_oe !== 4'h0)
         bad++;
      rc++;
   end
   // undriven lanes keep changing so a stale value never looks right
   always @(negedge sck)
   begin
      if (rc >= hdr && k * dw < 32)
      begin
         dq_i = chunk(k);
         k++;
      end
      else
         dq_i = ~dq_i;
   end
   always @(posedge ref_clk)
      if (cs_n)
         dq_i = ~dq_i;
endmodule

/* tb/testbench.sv */
/*
 self-checking bench for swf_top: registers, watermarks, flash reads.
 assumes swf_flash_model stands on the flash lanes.
*/
`timescale 1ns/10ps
`include "swf_cfg.svh"
module testbench;
   logic ref_clk, rst, reg_wr, reg_rd, mm_req, irq, mm_busy, mm_done;
   logic mm_err, sck, cs_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, mm_addr, mm_rdata, word;
   logic [3:0] tx_level, rx_level, dq_o, dq_oe, dq_i;
   logic [63:0] cap;
   logic [2:0] tm, rm;
   logic [1:0] en, p;
   swf_pkg::swf_fmt_t fmt, f;
   int bad, err_total, checks_done, i;

   swf_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_level(tx_level), .rx_level(rx_level),
      .irq(irq), .mm_req(mm_req), .mm_addr(mm_addr), .mm_busy(mm_busy),
      .mm_done(mm_done), .mm_err(mm_err), .mm_rdata(mm_rdata), .sck(sck),
      .cs_n(cs_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
   swf_flash_model flash (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n),
      .dq_o(dq_o), .dq_oe(dq_oe), .fmt(fmt), .word(word), .dq_i(dq_i),
      .cap(cap), .bad(bad));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ---------------------------------------------
   // register port, one-cycle strobes
   // ---------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge ref_clk);
   endtask
   function automatic logic [63:0] hexp(input swf_pkg::swf_fmt_t g,
      input logic [31:0] a);
      logic [63:0] e;
      int j, n;
      e = g.cmd_en ? 64'(g.cmd_code) : 64'h0;
      // address bytes beyond four are not sent
      for (j = (g.addr_len > 3'h4 ? 4 : int'(g.addr_len)) - 1; j >= 0; j--)
         e = (e << 8) | 64'(a[8*j +: 8]);
      n = g.addr_proto == 2'h1 ? 2 : (g.addr_proto == 2'h2 ? 4 : 1);
      for (j = 0; j < int'(g.pad_cnt) * n; j++)
      begin
         e = e << 1;
         if (j < 8)
            e[0] = g.pad_code[7-j];
      end
      return e;
   endfunction
   // ---------------------------------------------
   // mapped read, bounded wait for completion
   // ---------------------------------------------
   task automatic go(input logic [31:0] a, input logic e);
      int n;
      word = $urandom();
      mm_addr <= a;
      mm_req <= 1'b1;
      @(posedge ref_clk);
      mm_req <= 1'b0;
      n = 0;
      while (mm_done !== 1'b1 && n < 4000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 4000)
      begin
         err_total++;
         tally_and_finish();
      end
      else
      begin
         chk(mm_err, e);
         chk(mm_rdata, e ? 32'h0 : word);
         if (!e)
         begin
            chk(cap, hexp(fmt, a));
            chk(bad, 0);
         end
      end
   endtask

   initial
   begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_level = 4'h4;
      rx_level = 4'h0;
      mm_req = 1'b0;
      mm_addr = 32'h0;
      word = 32'h0;
      fmt = swf_pkg::swf_fmt_t'(32'h0003_0007);
      void'($urandom(32'h60d9d978));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      go($urandom(), 1'b0);
      rd(`SWF_OFF_TXMARK, 32'h1);
      rd(`SWF_OFF_RXMARK, 32'h0);
      rd(`SWF_OFF_FLASH_CTL, 32'h1);
      rd(`SWF_OFF_READ_FMT, 32'h0003_0007);
      rd(`SWF_OFF_IRQ_EN, 32'h0);
      rd(`SWF_OFF_IRQ_PEND, 32'h0);
      rd(8'h7c, 32'h0);
      wr(`SWF_OFF_READ_FMT, 32'hffff_ffff);
      rd(`SWF_OFF_READ_FMT, 32'hffff_3fff);
      $display("test registers done");
      for (i = 0; i < 24; i++)
      begin
         tm = 3'($urandom_range(7, 0));
         rm = 3'($urandom_range(7, 0));
         en = 2'($urandom_range(3, 0));
         wr(`SWF_OFF_TXMARK, {29'h0, tm});
         wr(`SWF_OFF_RXMARK, {29'h0, rm});
         wr(`SWF_OFF_IRQ_EN, {30'h0, en});
         wr(`SWF_OFF_IRQ_PEND, 32'hffff_ffff);
         tx_level <= i % 3 == 0 ? {1'b0, tm} : 4'($urandom_range(15, 0));
         rx_level <= i % 3 == 0 ? {1'b0, rm} : 4'($urandom_range(15, 0));
         repeat (3) @(posedge ref_clk);
         p = {rx_level > {1'b0, rm}, tx_level < {1'b0, tm}};
         rd(`SWF_OFF_IRQ_PEND, {30'h0, p});
         chk(irq, |(p & en));
      end
      $display("test watermark done");
      for (i = 0; i < 12; i++)
      begin
         f = swf_pkg::swf_fmt_t'($urandom());
         f.addr_len = 3'(i % 6);
         f.pad_cnt = 4'($urandom_range(3, 0));
         f.cmd_proto = 2'(i % 3);
         f.addr_proto = 2'((i + 1) % 3);
         f.data_proto = 2'((i + 2) % 3);
         fmt = f;
         wr(`SWF_OFF_READ_FMT, f);
         go($urandom(), 1'b0);
      end
      wr(`SWF_OFF_FLASH_CTL, 32'h0);
      go($urandom(), 1'b1);
      wr(`SWF_OFF_FLASH_CTL, 32'h1);
      go($urandom(), 1'b0);
      $display("test flash done");
      tally_and_finish();
   end
endmodule
